//--- bench/preset_link_props.sv
// concurrent checks on the controller-to-device command link
`timescale 1ns/1ns
module preset_link_props
  import preset_store_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [7:0] cmd_mode_type,
  input wire logic [31:0] cmd_addr,
  input wire logic [31:0] cmd_data,
  input wire logic rsp_valid,
  input wire logic [3:0] rsp_alarm,
  input wire logic [31:0] servo_command_io
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  logic [31:0] last_addr_q;
  logic [15:0] last_data_q;
  wire take = cmd_valid && cmd_ready;
  wire is_run = cmd_addr == EXEC_CTRL_ADDR && cmd_data[15:0] == EXEC_RUN;
  wire is_long = cmd_mode_type == CODE_LONG_VOL;
  // remember the previous command so a run can be tied to its prepare
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      last_addr_q <= 32'h00000000;
      last_data_q <= 16'h0000;
    end else if (take) begin
      last_addr_q <= cmd_addr;
      last_data_q <= cmd_data[15:0];
    end
  end
  chk_rsp_follows: assert property (take |=> rsp_valid)
    else $error("no response one cycle after a taken command");
  chk_rsp_single: assert property (rsp_valid |=> !rsp_valid)
    else $error("response wider than one cycle");
  chk_rsp_cause: assert property (rsp_valid |-> $past(take))
    else $error("response without a taken command");
  chk_ready_busy: assert property (rsp_valid |-> !cmd_ready)
    else $error("ready high during response");
  chk_cmd_hold: assert property (cmd_valid && !cmd_ready |=>
    cmd_valid && $stable(cmd_addr) && $stable(cmd_data))
    else $error("command changed before it was taken");
  chk_mode_legal: assert property (cmd_valid |->
    is_long || cmd_mode_type == CODE_SHORT_VOL)
    else $error("controller sent an unexpected storage/width code");
  chk_addr_align: assert property (cmd_valid |->
    (is_long ? cmd_addr[1:0] == 2'b00 : cmd_addr[0] == 1'b0))
    else $error("controller sent a misaligned address");
  chk_no_alarm: assert property (rsp_valid |->
    rsp_alarm == ALARM_NONE)
    else $error("alarm on a well formed command");
  chk_run_order: assert property (take && is_run |->
    last_addr_q == EXEC_CTRL_ADDR && last_data_q == EXEC_PREPARE)
    else $error("run issued without prepare step before it");
  chk_io_reserved: assert property (
    (servo_command_io & 32'hBFFFFFFF) == 32'h00000000)
    else $error("reserved io bits driven high");
  cov_run: cover property (take && is_run);
  cov_init: cover property (take && cmd_addr == OP_SEL_ADDR
    && cmd_data[15:0] == OP_INIT);
  cov_stop: cover property ($rose(servo_command_io[STOP_BIT]));
endmodule

//--- bench/tb.sv
// top bench: controller and device joined, plus a lone device for faults
`timescale 1ns/1ns
module tb;
  import preset_store_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, pos1, nv1, pos2, nv2;
  logic stop1, stop2, sv1, in1, sv2, in2;
  logic [3:0] al;
  logic [7:0] bad_mt [4] = '{8'h13, 8'h14, 8'h33, 8'h12};
  logic [31:0] bad_a [4] = '{32'hF0050002, TABLE_BASE_ADDR,
    TABLE_BASE_ADDR, 32'h80004003};
  logic [31:0] seq_a [6] = '{REQ_CODE_ADDR, OP_SEL_ADDR, TARGET_ADDR_ADDR,
    EXEC_CTRL_ADDR, EXEC_CTRL_ADDR, REQ_CODE_ADDR};
  logic [31:0] seq_d [6] = '{32'h2025, 32'h0, TABLE_BASE_ADDR, 32'h2,
    32'h1, 32'h0};
  int fails = 0, comparisons = 0, n_sv1 = 0, n_in1 = 0, n_sv2 = 0;
  preset_link_if link ();
  preset_link_if link2 ();
  always #2 i_mclk = ~i_mclk;
  preset_store_host preset_store_host_inst (.i_mclk(i_mclk),
    .i_rst_n(i_rst_n), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_awaddr(awaddr), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb),
    .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .o_s_axi_bresp(bresp), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .i_s_axi_araddr(araddr),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .link(link.host));
  preset_store_device preset_store_device_inst (.i_mclk(i_mclk),
    .i_rst_n(i_rst_n), .link(link.device), .o_preset_stop(stop1),
    .o_first_position(pos1), .o_nv_first(nv1), .o_nv_saved(sv1),
    .o_nv_inited(in1));
  // second device faces the bench directly so faults can be injected
  preset_store_device preset_store_device_inst2 (.i_mclk(i_mclk),
    .i_rst_n(i_rst_n), .link(link2.device), .o_preset_stop(stop2),
    .o_first_position(pos2), .o_nv_first(nv2), .o_nv_saved(sv2),
    .o_nv_inited(in2));
  preset_link_props preset_link_props_inst (.i_mclk(i_mclk),
    .i_rst_n(i_rst_n), .cmd_valid(link.cmd_valid),
    .cmd_ready(link.cmd_ready), .cmd_mode_type(link.cmd_mode_type),
    .cmd_addr(link.cmd_addr), .cmd_data(link.cmd_data),
    .rsp_valid(link.rsp_valid), .rsp_alarm(link.rsp_alarm),
    .servo_command_io(link.servo_command_io));
  always @(posedge i_mclk) begin
    if (sv1 === 1'b1) n_sv1++;
    if (in1 === 1'b1) n_in1++;
    if (sv2 === 1'b1) n_sv2++;
  end
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    @(posedge i_mclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge i_mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    check({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge i_mclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge i_mclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    check(d, e);
    check({30'h0, r}, {30'h0, er});
  endtask
  // polls status; the watchdog bounds a sequence that never finishes
  task automatic wait_idle();
    logic [31:0] d;
    logic [1:0] r;
    do axi_rd(REG_STATUS, d, r);
    while (d[STAT_BUSY_BIT] !== 1'b0);
  endtask
  task automatic dsend(input logic [7:0] mt, input logic [31:0] a,
    input logic [31:0] d);
    @(posedge i_mclk);
    link2.cmd_valid <= 1'b1;
    link2.cmd_mode_type <= mt;
    link2.cmd_addr <= a;
    link2.cmd_data <= d;
    do @(posedge i_mclk);
    while (link2.cmd_ready !== 1'b1);
    link2.cmd_valid <= 1'b0;
    link2.cmd_addr <= ~a;
    link2.cmd_data <= ~d;
    do @(posedge i_mclk);
    while (link2.rsp_valid !== 1'b1);
    al = link2.rsp_alarm;
  endtask
  initial begin
    repeat (20000) @(posedge i_mclk);
    fails++;
    conclude();
  end
  initial begin
    link2.cmd_valid = 1'b0;
    link2.cmd_mode_type = 8'h00;
    link2.cmd_addr = 32'h00000000;
    link2.cmd_data = 32'h00000000;
    link2.servo_command_io = 32'h00000000;
    repeat (10) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rd_chk(REG_STATUS, 32'h00000000, RESP_OKAY);
    check(pos1 | nv1 | {31'h0, stop1}, 32'h00000000);
    rd_chk(8'h0C, 32'h00000000, RESP_SLVERR);
    axi_wr(8'h0C, 32'h0000000F, RESP_SLVERR);
    $display("test reset and map done");
    axi_wr(REG_POS, 32'h000186A0, RESP_OKAY);
    rd_chk(REG_POS, 32'h000186A0, RESP_OKAY);
    axi_wr(REG_CTRL, 32'h00000008, RESP_OKAY);
    wait_idle();
    check(pos1, 32'h000186A0);
    $display("test table write done");
    axi_wr(REG_CTRL, 32'h00000001, RESP_OKAY);
    wait_idle();
    check(nv1, 32'h000186A0);
    check(32'(n_sv1), 32'h00000001);
    rd_chk(REG_STATUS, 32'h00000002, RESP_OKAY);
    $display("test save done");
    axi_wr(REG_CTRL, 32'h00000002, RESP_OKAY);
    wait_idle();
    check(nv1, NV_DEFAULT);
    check(32'(n_in1), 32'h00000001);
    check(pos1, 32'h000186A0);
    rd_chk(REG_STATUS, 32'h00000002, RESP_OKAY);
    $display("test init done");
    axi_wr(REG_CTRL, 32'h00000004, RESP_OKAY);
    repeat (3) @(posedge i_mclk);
    check({31'h0, stop1}, 32'h00000001);
    check(link.servo_command_io, 32'h40000000);
    rd_chk(REG_CTRL, 32'h00000004, RESP_OKAY);
    rd_chk(REG_STATUS, 32'h0000000A, RESP_OKAY);
    axi_wr(REG_CTRL, 32'h00000000, RESP_OKAY);
    repeat (3) @(posedge i_mclk);
    check({31'h0, stop1}, 32'h00000000);
    $display("test stop done");
    for (int i = 0; i < 4; i++) begin
      dsend(bad_mt[i], bad_a[i], 32'h00000001);
      check({28'h0, al}, {28'h0, ALARM_CMD});
    end
    check(pos2, 32'h00000000);
    dsend(CODE_LONG_VOL, TABLE_BASE_ADDR, 32'h000055AA);
    check(pos2, 32'h000055AA);
    // a run with no preparation must leave storage untouched
    dsend(CODE_SHORT_VOL, EXEC_CTRL_ADDR, 32'h00000001);
    repeat (2) @(posedge i_mclk);
    check(32'(n_sv2) | nv2, 32'h00000000);
    for (int i = 0; i < 6; i++) begin
      dsend(i == 2 ? CODE_LONG_VOL : CODE_SHORT_VOL, seq_a[i], seq_d[i]);
      check({28'h0, al}, {28'h0, ALARM_NONE});
    end
    check(nv2, 32'h000055AA);
    check(32'(n_sv2), 32'h00000001);
    link2.servo_command_io <= 32'hBFFFFFFF;
    repeat (2) @(posedge i_mclk);
    check({31'h0, stop2}, 32'h00000000);
    link2.servo_command_io <= 32'hFFFFFFFF;
    repeat (2) @(posedge i_mclk);
    check({31'h0, stop2}, 32'h00000001);
    link2.servo_command_io <= 32'h00000000;
    repeat (2) @(posedge i_mclk);
    check({31'h0, stop2}, 32'h00000000);
    $display("test lone device done");
    conclude();
  end
endmodule

//--- hw/preset_link_if.sv
// command link between the controller and the preset store device
`timescale 1ns/1ns
interface preset_link_if;
  logic cmd_valid;
  logic cmd_ready;
  logic [7:0] cmd_mode_type;
  logic [31:0] cmd_addr;
  logic [31:0] cmd_data;
  logic rsp_valid;
  logic [3:0] rsp_alarm;
  logic [31:0] servo_command_io;
  modport device(input cmd_valid, cmd_mode_type, cmd_addr, cmd_data,
    servo_command_io, output cmd_ready, rsp_valid, rsp_alarm);
  modport host(output cmd_valid, cmd_mode_type, cmd_addr, cmd_data,
    servo_command_io, input cmd_ready, rsp_valid, rsp_alarm);
endinterface

//--- hw/preset_store_device.sv
// device end: command decode, save/init sequence, preset output stop
`timescale 1ns/1ns
module preset_store_device
  import preset_store_pkg::*;
#(
  parameter int TABLE_WORDS = 4
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  preset_link_if.device link,
  output logic o_preset_stop,
  output logic [31:0] o_first_position,
  output logic [31:0] o_nv_first,
  output logic o_nv_saved,
  output logic o_nv_inited
);
  localparam int IW = $clog2(TABLE_WORDS);

  generate
    if (TABLE_WORDS < 2 || (1 << IW) != TABLE_WORDS) begin : g_chk
      $error("TABLE_WORDS must be a power of two, at least 2");
    end
  endgenerate

  typedef enum {SEQ_IDLE, SEQ_ARMED, SEQ_OPSEL, SEQ_TARGET, SEQ_PREPARED,
    SEQ_DONE} seq_t;

  seq_t seq_q;
  logic op_init_q;
  logic rsp_valid_q;
  logic [3:0] rsp_alarm_q;
  logic stop_q;
  logic stop_prev_q;
  logic saved_q;
  logic inited_q;
  logic [31:0] vol_q [TABLE_WORDS];
  logic [31:0] nv_q [TABLE_WORDS];

  wire [3:0] mode = link.cmd_mode_type[7:4];
  wire [3:0] dtype = link.cmd_mode_type[3:0];
  wire [31:0] addr = link.cmd_addr;
  wire [15:0] sdata = link.cmd_data[15:0];
  wire take = link.cmd_valid & link.cmd_ready;
  wire bad_code = !(mode == MODE_VOLATILE || mode == MODE_NONVOLATILE) ||
    !(dtype == TYPE_BYTE || dtype == TYPE_SHORT || dtype == TYPE_LONG);
  wire misaligned = (dtype == TYPE_SHORT && addr[0]) ||
    (dtype == TYPE_LONG && addr[1:0] != 2'b00);
  wire cmd_ok = take & !bad_code & !misaligned;
  wire short_wr = cmd_ok & (dtype == TYPE_SHORT);
  wire long_wr = cmd_ok & (dtype == TYPE_LONG);
  wire tbl_hit = long_wr & (mode == MODE_VOLATILE) &
    (addr[31:IW+2] == TABLE_BASE_ADDR[31:IW+2]);
  wire [IW-1:0] tbl_idx = addr[IW+1:2];
  wire req_wr = short_wr & (addr == REQ_CODE_ADDR);
  wire opsel_wr = short_wr & (addr == OP_SEL_ADDR);
  wire target_wr = long_wr & (addr == TARGET_ADDR_ADDR);
  wire exec_wr = short_wr & (addr == EXEC_CTRL_ADDR);
  wire run_go = exec_wr & (sdata == EXEC_RUN) & (seq_q == SEQ_PREPARED);
  // the stop bit is the only field bit looked at; the rest are don't care
  wire stop_bit = link.servo_command_io[STOP_BIT];

  // one answer per command; the next is taken only after it
  assign link.cmd_ready = !rsp_valid_q;
  assign link.rsp_valid = rsp_valid_q;
  assign link.rsp_alarm = rsp_alarm_q;
  assign o_preset_stop = stop_q;
  assign o_first_position = vol_q[0];
  assign o_nv_first = nv_q[0];
  assign o_nv_saved = saved_q;
  assign o_nv_inited = inited_q;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rsp_valid_q <= 1'b0;
      rsp_alarm_q <= ALARM_NONE;
    end else begin
      rsp_valid_q <= take;
      if (take) begin
        rsp_alarm_q <= cmd_ok ? ALARM_NONE : ALARM_CMD;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seq_q <= SEQ_IDLE;
      op_init_q <= 1'b0;
    end else begin
      case (seq_q)
        SEQ_IDLE: begin
          if (req_wr && sdata == REQ_CODE_START) begin
            seq_q <= SEQ_ARMED;
          end
        end
        SEQ_ARMED: begin
          if (opsel_wr && (sdata == OP_SAVE || sdata == OP_INIT)) begin
            seq_q <= SEQ_OPSEL;
            op_init_q <= (sdata == OP_INIT);
          end
        end
        SEQ_OPSEL: begin
          if (target_wr && link.cmd_data == TABLE_BASE_ADDR) begin
            seq_q <= SEQ_TARGET;
          end
        end
        SEQ_TARGET: begin
          if (exec_wr && sdata == EXEC_PREPARE) begin
            seq_q <= SEQ_PREPARED;
          end
        end
        SEQ_PREPARED: begin
          if (run_go) begin
            seq_q <= SEQ_DONE;
          end
        end
        SEQ_DONE: begin
        end
        default: begin
          seq_q <= SEQ_IDLE;
        end
      endcase
      // out-of-order steps other than the end code leave the state alone, so a stray run is dropped
      if (req_wr && sdata == REQ_CODE_END) begin
        seq_q <= SEQ_IDLE;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < TABLE_WORDS; i++) begin
        vol_q[i] <= NV_DEFAULT;
        nv_q[i] <= NV_DEFAULT;
      end
      saved_q <= 1'b0;
      inited_q <= 1'b0;
    end else begin
      saved_q <= run_go & !op_init_q;
      inited_q <= run_go & op_init_q;
      if (tbl_hit) begin
        vol_q[tbl_idx] <= link.cmd_data;
      end
      for (int i = 0; i < TABLE_WORDS; i++) begin
        if (run_go) begin
          nv_q[i] <= op_init_q ? NV_DEFAULT : vol_q[i];
        end
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stop_prev_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      stop_prev_q <= stop_bit;
      if (stop_bit && !stop_prev_q) begin
        stop_q <= 1'b1;
      end else if (!stop_bit) begin
        stop_q <= 1'b0;
      end
    end
  end
endmodule

//--- hw/preset_store_host.sv
// controller end: axi4-lite registers driving the save/init sequences
`timescale 1ns/1ns
module preset_store_host
  import preset_store_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [7:0] i_s_axi_araddr,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  preset_link_if.host link
);
  typedef enum {H_IDLE, H_ISSUE, H_WAIT} hst_t;

  hst_t st_q;
  logic [2:0] step_q;
  logic op_init_q;
  logic pos_only_q;
  logic stop_q;
  logic done_q;
  logic err_q;
  logic [3:0] alarm_q;
  logic [31:0] pos_q;
  logic [7:0] code_q;
  logic [31:0] addr_q;
  logic [31:0] data_q;
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // 0 none, 1 ctrl, 2 pos, 3 status
  function automatic logic [1:0] reg_sel(input logic [7:0] a);
    if (a == REG_CTRL) begin
      return 2'd1;
    end else if (a == REG_POS) begin
      return 2'd2;
    end else if (a == REG_STATUS) begin
      return 2'd3;
    end
    return 2'd0;
  endfunction

  // code, address and data of each step of the fixed sequence
  function automatic logic [71:0] seq_cmd(input logic [2:0] s,
    input logic init);
    case (s)
      3'd0: return {CODE_SHORT_VOL, REQ_CODE_ADDR,
        16'h0000, REQ_CODE_START};
      3'd1: return {CODE_SHORT_VOL, OP_SEL_ADDR, 16'h0000,
        init ? OP_INIT : OP_SAVE};
      3'd2: return {CODE_LONG_VOL, TARGET_ADDR_ADDR,
        TABLE_BASE_ADDR};
      3'd3: return {CODE_SHORT_VOL, EXEC_CTRL_ADDR,
        16'h0000, EXEC_PREPARE};
      3'd4: return {CODE_SHORT_VOL, EXEC_CTRL_ADDR,
        16'h0000, EXEC_RUN};
      default: return {CODE_SHORT_VOL, REQ_CODE_ADDR,
        16'h0000, REQ_CODE_END};
    endcase
  endfunction

  wire wr_fire = aw_have_q & w_have_q & !bvalid_q;
  wire [1:0] wsel = reg_sel(awaddr_q);
  wire [1:0] rsel = reg_sel(i_s_axi_araddr);
  wire ctrl_wr = wr_fire & (wsel == 2'd1) & wstrb_q[0];
  wire pos_wr = wr_fire & (wsel == 2'd2);
  wire idle = (st_q == H_IDLE);
  wire go_save = ctrl_wr & idle & wdata_q[CTRL_SAVE_BIT];
  wire go_init = ctrl_wr & idle & wdata_q[CTRL_INIT_BIT] & !go_save;
  wire go_pos = ctrl_wr & idle & wdata_q[CTRL_POS_BIT] & !go_save &
    !wdata_q[CTRL_INIT_BIT];
  wire go_seq = go_save | go_init;
  wire ar_take = i_s_axi_arvalid & !rvalid_q;
  wire [2:0] last_step = pos_only_q ? 3'd0 : 3'(LAST_SEQ_STEP);
  wire [2:0] step_nx = step_q + 3'd1;
  wire [71:0] nx_cmd = seq_cmd(step_nx, op_init_q);
  wire [71:0] first_cmd = seq_cmd(3'd0, go_init);
  wire [31:0] status_w = {24'h000000, alarm_q, stop_q, err_q, done_q,
    !idle};
  wire [31:0] ctrl_w = 32'(stop_q) << CTRL_STOP_BIT;
  wire [31:0] rd_mux = (rsel == 2'd1) ? ctrl_w :
    (rsel == 2'd2) ? pos_q : (rsel == 2'd3) ? status_w : 32'h00000000;

  assign o_s_axi_awready = !aw_have_q;
  assign o_s_axi_wready = !w_have_q;
  assign o_s_axi_bvalid = bvalid_q;
  assign o_s_axi_bresp = bresp_q;
  assign o_s_axi_arready = !rvalid_q;
  assign o_s_axi_rvalid = rvalid_q;
  assign o_s_axi_rdata = rdata_q;
  assign o_s_axi_rresp = rresp_q;
  assign link.cmd_valid = (st_q == H_ISSUE);
  assign link.cmd_mode_type = code_q;
  assign link.cmd_addr = addr_q;
  assign link.cmd_data = data_q;
  // reserved bits of the field stay zero
  assign link.servo_command_io = 32'(stop_q) << STOP_BIT;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (i_s_axi_awvalid && !aw_have_q) begin
        aw_have_q <= 1'b1;
        awaddr_q <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && !w_have_q) begin
        w_have_q <= 1'b1;
        wdata_q <= i_s_axi_wdata;
        wstrb_q <= i_s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wsel == 2'd0) ? RESP_SLVERR : RESP_OKAY;
      end else if (i_s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= (rsel == 2'd0) ? RESP_SLVERR : RESP_OKAY;
    end else if (i_s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  for (genvar b = 0; b < 4; b++) begin : g_pos
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        pos_q[8*b +: 8] <= 8'h00;
      end else if (pos_wr && wstrb_q[b]) begin
        pos_q[8*b +: 8] <= wdata_q[8*b +: 8];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stop_q <= 1'b0;
    end else if (ctrl_wr) begin
      // raise to halt, e.g. during origin return; clear to resume
      stop_q <= wdata_q[CTRL_STOP_BIT];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= H_IDLE;
      step_q <= 3'd0;
      op_init_q <= 1'b0;
      pos_only_q <= 1'b0;
      done_q <= 1'b0;
      err_q <= 1'b0;
      alarm_q <= ALARM_NONE;
      code_q <= 8'h00;
      addr_q <= 32'h00000000;
      data_q <= 32'h00000000;
    end else begin
      case (st_q)
        H_IDLE: begin
          if (go_seq || go_pos) begin
            st_q <= H_ISSUE;
            step_q <= 3'd0;
            op_init_q <= go_init;
            pos_only_q <= go_pos;
            done_q <= 1'b0;
            err_q <= 1'b0;
            alarm_q <= ALARM_NONE;
            if (go_pos) begin
              {code_q, addr_q, data_q} <=
                {CODE_LONG_VOL, TABLE_BASE_ADDR, pos_q};
            end else begin
              {code_q, addr_q, data_q} <= first_cmd;
            end
          end
        end
        H_ISSUE: begin
          if (link.cmd_ready) begin
            st_q <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (link.rsp_valid) begin
            alarm_q <= link.rsp_alarm;
            if (link.rsp_alarm != ALARM_NONE) begin
              // abort; the device keeps its sequence state until an end code is sent
              st_q <= H_IDLE;
              err_q <= 1'b1;
            end else if (step_q == last_step) begin
              st_q <= H_IDLE;
              done_q <= 1'b1;
            end else begin
              // next step only after the previous one is answered
              st_q <= H_ISSUE;
              step_q <= step_nx;
              {code_q, addr_q, data_q} <= nx_cmd;
            end
          end
        end
        default: begin
          st_q <= H_IDLE;
        end
      endcase
    end
  end
endmodule

//--- hw/preset_store_pkg.sv
// constants shared by both ends of the preset output parameter link
package preset_store_pkg;
  // device locations
  localparam logic [31:0] TABLE_BASE_ADDR = 32'hF0050000;
  localparam logic [31:0] REQ_CODE_ADDR = 32'h80004000;
  localparam logic [31:0] OP_SEL_ADDR = 32'h800041E0;
  localparam logic [31:0] TARGET_ADDR_ADDR = 32'h800041E4;
  localparam logic [31:0] EXEC_CTRL_ADDR = 32'h80004002;
  // data values
  localparam logic [15:0] REQ_CODE_START = 16'h2025;
  localparam logic [15:0] REQ_CODE_END = 16'h0000;
  localparam logic [15:0] OP_SAVE = 16'h0000;
  localparam logic [15:0] OP_INIT = 16'h0003;
  localparam logic [15:0] EXEC_PREPARE = 16'h0002;
  localparam logic [15:0] EXEC_RUN = 16'h0001;
  localparam logic [31:0] NV_DEFAULT = 32'h00000000;
  // storage and width code
  localparam logic [3:0] MODE_VOLATILE = 4'h1;
  localparam logic [3:0] MODE_NONVOLATILE = 4'h2;
  localparam logic [3:0] TYPE_BYTE = 4'h1;
  localparam logic [3:0] TYPE_SHORT = 4'h2;
  localparam logic [3:0] TYPE_LONG = 4'h3;
  localparam logic [7:0] CODE_SHORT_VOL = 8'h12;
  localparam logic [7:0] CODE_LONG_VOL = 8'h13;
  // servo command io field
  localparam int STOP_BIT = 30;
  // command alarm codes
  localparam logic [3:0] ALARM_NONE = 4'h0;
  localparam logic [3:0] ALARM_CMD = 4'h9;
  // controller register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_POS = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam int CTRL_SAVE_BIT = 0;
  localparam int CTRL_INIT_BIT = 1;
  localparam int CTRL_STOP_BIT = 2;
  localparam int CTRL_POS_BIT = 3;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_ERR_BIT = 2;
  localparam int STAT_STOP_BIT = 3;
  localparam int STAT_ALARM_LSB = 4;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int LAST_SEQ_STEP = 5;
endpackage
